// >>> hdl/int_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

// Fixed-priority arbiter: the lowest source index wins. N may be raised up to MAX_SRC.
module int_arbiter #(
  parameter int unsigned N = sysint_pkg::NUM_SRC
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Sources and CPU vector fetch
  input  wire logic [N-1:0] int_req,
  input  wire logic         vector_fetch,
  // Results
  output logic              pending,
  output logic [15:0]       vector,
  output logic [N-1:0]      src_ack
);

  localparam int unsigned IW = sysint_pkg::SRC_IDX_W;
  localparam int unsigned VW = sysint_pkg::VEC_W;

  typedef struct packed {
    logic          pending;
    logic [VW-1:0] vector;
    logic [N-1:0]  ack;
  } arb_state_t;

  arb_state_t s_q;
  arb_state_t s_d;
  logic [IW-1:0] win;

  function automatic logic [IW-1:0] first_set(input logic [N-1:0] r);
    logic [IW-1:0] k;
    k = '0;
    for (int i = N - 1; i >= 0; i--)
      if (r[i])
        k = IW'(i);
    return k;
  endfunction : first_set

  always_comb
  begin
    s_d = s_q;
    win = first_set(int_req);
    s_d.pending = |int_req;
    s_d.ack = '0;
    // The vector is latched at the fetch so a late request cannot change it mid-fetch.
    if (vector_fetch && (|int_req))
    begin
      s_d.vector = sysint_pkg::VECTOR_TOP - VW'({win, 1'b0});
      s_d.ack = N'(1) << win;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pending = s_q.pending;
  assign vector  = s_q.vector;
  assign src_ack = s_q.ack;

  a_ack_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(src_ack)) else $error("more than one source acknowledged");
  a_vec_prio: assert property (@(posedge pclk) disable iff (!presetn)
    vector_fetch && int_req[0] |=> src_ack[0] && vector == sysint_pkg::VECTOR_TOP)
    else $error("top priority source not served first");

endmodule : int_arbiter

`default_nettype wire

// >>> hdl/sysint_pkg.sv
package sysint_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [15:0] IDX_BREAK_STATUS       = 16'hfe00;
  localparam logic [15:0] IDX_RESET_CAUSE        = 16'hfe01;
  localparam logic [15:0] IDX_BREAK_FLAG_CONTROL = 16'hfe03;
  localparam logic [15:0] IDX_IRQ_STATUS         = 16'hfe04;
  localparam logic [15:0] IDX_IRQ_MASK           = 16'hfe05;

  // Field positions.
  localparam int unsigned BREAK_WAIT_BIT  = 1;
  localparam int unsigned CLEAR_EN_BIT    = 7;
  localparam int unsigned RC_POWER_ON     = 7;
  localparam int unsigned RC_PIN          = 6;
  localparam int unsigned RC_WATCHDOG     = 5;
  localparam int unsigned RC_BAD_OPCODE   = 4;
  localparam int unsigned RC_BAD_ADDRESS  = 3;
  localparam int unsigned RC_LOW_VOLTAGE  = 1;
  localparam int unsigned EV_CAUSE        = 0;
  localparam int unsigned EV_BREAK_WAIT   = 1;
  localparam int unsigned EV_STARTUP_DONE = 2;
  localparam int unsigned IRQ_W           = 3;

  // Writable masks and reset values.
  localparam logic [7:0]       BREAK_STATUS_MASK = 8'h02;
  localparam logic [7:0]       BFC_MASK          = 8'h80;
  localparam logic [7:0]       RESET_CAUSE_POR   = 8'h80;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST      = 3'h0;

  // Startup hold, in buffered oscillator cycles.
  localparam logic [12:0] STARTUP_CYCLES = 13'h1000;
  localparam logic [12:0] STARTUP_LAST   = STARTUP_CYCLES - 13'h1;

  // Interrupt arbitration.
  localparam int unsigned NUM_SRC   = 24;
  localparam int unsigned MAX_SRC   = 128;
  localparam int unsigned SRC_IDX_W = 7;
  localparam int unsigned VEC_W     = 16;
  localparam logic [15:0] VECTOR_TOP = 16'hfffc;

  typedef enum logic [0:0] {BOOT_HOLD, BOOT_RUN} boot_t;

  typedef struct packed {
    logic power_on_pulse;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch_address;
    logic low_voltage;
  } reset_src_t;

  typedef struct packed {
    boot_t            boot;
    logic [12:0]      count;
    logic             bus_clock;
    logic             clocks_run;
    logic             rst_pin_out;
    logic             rst_pin_oe;
    logic [7:0]       break_status;
    logic [7:0]       reset_cause;
    logic [7:0]       break_flag_control;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } sys_state_t;

  localparam sys_state_t STATE_RST = '{
    boot: BOOT_HOLD, count: 13'h0, bus_clock: 1'b0, clocks_run: 1'b0,
    rst_pin_out: 1'b0, rst_pin_oe: 1'b1, break_status: 8'h00,
    reset_cause: RESET_CAUSE_POR, break_flag_control: 8'h00,
    irq_status: 3'h0, irq_mask: IRQ_MASK_RST, irq: 1'b0,
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0
  };

endpackage : sysint_pkg

// >>> hdl/system_integration_unit.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module system_integration_unit (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [31:0]                 prdata,
  // Reset sources
  input  wire sysint_pkg::reset_src_t reset_src,
  // Reset pin, open drain
  input  wire logic                   rst_pin_i,
  output logic                        rst_pin_o,
  output logic                        rst_pin_oe,
  // Break
  input  wire logic                   break_active,
  input  wire logic                   break_wait_set,
  // Clock control
  output logic                        bus_clock,
  output logic                        clocks_run,
  // Interrupt sources and CPU fetch
  input  wire logic [23:0]            int_req,
  input  wire logic                   int_vector_fetch,
  output logic                        int_pending,
  output logic [15:0]                 int_vector,
  output logic [23:0]                 int_src_ack,
  // Status interrupt
  output logic                        irq
);

  sysint_pkg::sys_state_t s_q;
  sysint_pkg::sys_state_t s_d;

  logic [15:0]                  idx;
  logic                         hit;
  logic                         access;
  logic                         wr_done;
  logic                         restart;
  logic                         pin_low;
  logic                         clear_ok;
  logic                         startup_ev;
  logic [7:0]                   cause_bits;
  logic [sysint_pkg::IRQ_W-1:0] ev;

  function automatic logic reg_hit(input logic [31:0] a);
    logic [15:0] i;
    i = a[17:2];
    return (a[31:18] == 14'h0) && (a[1:0] == 2'h0) &&
      ((i == sysint_pkg::IDX_BREAK_STATUS) || (i == sysint_pkg::IDX_RESET_CAUSE) ||
       (i == sysint_pkg::IDX_BREAK_FLAG_CONTROL) || (i == sysint_pkg::IDX_IRQ_STATUS) ||
       (i == sysint_pkg::IDX_IRQ_MASK));
  endfunction : reg_hit

  function automatic logic [7:0] read_byte(input logic [15:0] i,
                                           input sysint_pkg::sys_state_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      sysint_pkg::IDX_BREAK_STATUS:
        v = s.break_status & sysint_pkg::BREAK_STATUS_MASK;
      sysint_pkg::IDX_RESET_CAUSE:
        v = s.reset_cause;
      sysint_pkg::IDX_BREAK_FLAG_CONTROL:
        v = s.break_flag_control & sysint_pkg::BFC_MASK;
      sysint_pkg::IDX_IRQ_STATUS:
        v = 8'(s.irq_status);
      sysint_pkg::IDX_IRQ_MASK:
        v = 8'(s.irq_mask);
      default:
        v = 8'h00;
    endcase
    return v;
  endfunction : read_byte

  always_comb
  begin
    s_d = s_q;
    idx = paddr[17:2];
    hit = reg_hit(paddr);
    access = psel && penable;
    wr_done = access && s_q.pready && pwrite && hit;
    restart = reset_src.power_on_pulse || reset_src.low_voltage;
    // The pin reads low while we drive it, so only a low we are not causing counts.
    pin_low = !rst_pin_i && !s_q.rst_pin_oe;
    startup_ev = 1'b0;

    // Startup hold and divided bus clock.
    unique case (s_q.boot)
      sysint_pkg::BOOT_HOLD:
      begin
        if (s_q.count == sysint_pkg::STARTUP_LAST)
        begin
          s_d.boot = sysint_pkg::BOOT_RUN;
          s_d.clocks_run = 1'b1;
          s_d.rst_pin_oe = 1'b0;
          startup_ev = 1'b1;
        end
        else
        begin
          s_d.count = s_q.count + 13'h1;
        end
      end
      sysint_pkg::BOOT_RUN:
      begin
        s_d.bus_clock = !s_q.bus_clock;
      end
    endcase
    if (restart)
    begin
      s_d.boot = sysint_pkg::BOOT_HOLD;
      s_d.count = 13'h0;
      s_d.clocks_run = 1'b0;
      s_d.bus_clock = 1'b0;
      s_d.rst_pin_oe = 1'b1;
    end
    s_d.rst_pin_out = 1'b0;

    // Reset cause flags; writes never reach this register.
    cause_bits = 8'h00;
    cause_bits[sysint_pkg::RC_PIN] = pin_low;
    cause_bits[sysint_pkg::RC_WATCHDOG] = reset_src.watchdog;
    cause_bits[sysint_pkg::RC_BAD_OPCODE] = reset_src.bad_opcode;
    cause_bits[sysint_pkg::RC_BAD_ADDRESS] = reset_src.bad_fetch_address;
    cause_bits[sysint_pkg::RC_LOW_VOLTAGE] = reset_src.low_voltage;
    if (reset_src.power_on_pulse)
      s_d.reset_cause = sysint_pkg::RESET_CAUSE_POR;
    else
      s_d.reset_cause = s_q.reset_cause | cause_bits;

    // Break wait flag: software clears it by writing zero, gated while in break.
    clear_ok = !break_active || s_q.break_flag_control[sysint_pkg::CLEAR_EN_BIT];
    if (wr_done && (idx == sysint_pkg::IDX_BREAK_STATUS) &&
        !pwdata[sysint_pkg::BREAK_WAIT_BIT] && clear_ok)
      s_d.break_status[sysint_pkg::BREAK_WAIT_BIT] = 1'b0;
    if (break_wait_set)
      s_d.break_status[sysint_pkg::BREAK_WAIT_BIT] = 1'b1;
    s_d.break_status = s_d.break_status & sysint_pkg::BREAK_STATUS_MASK;

    if (wr_done && (idx == sysint_pkg::IDX_BREAK_FLAG_CONTROL))
      s_d.break_flag_control = pwdata[7:0] & sysint_pkg::BFC_MASK;

    // Sticky event bits; a new event wins over a clear in the same cycle.
    ev = '0;
    ev[sysint_pkg::EV_CAUSE] = |cause_bits;
    ev[sysint_pkg::EV_BREAK_WAIT] = break_wait_set;
    ev[sysint_pkg::EV_STARTUP_DONE] = startup_ev;
    if (wr_done && (idx == sysint_pkg::IDX_IRQ_STATUS))
      s_d.irq_status = s_q.irq_status & ~pwdata[sysint_pkg::IRQ_W-1:0];
    s_d.irq_status = s_d.irq_status | ev;
    if (wr_done && (idx == sysint_pkg::IDX_IRQ_MASK))
      s_d.irq_mask = pwdata[sysint_pkg::IRQ_W-1:0];
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);

    // One wait state: the answer comes in the second access cycle.
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (access && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      s_d.pslverr = !hit;
      s_d.prdata = (hit && !pwrite) ? {24'h0, read_byte(idx, s_q)} : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= sysint_pkg::STATE_RST;
    else
      s_q <= s_d;
  end

  int_arbiter #(
    .N (sysint_pkg::NUM_SRC)
  ) u_arbiter (
    .pclk         (pclk),
    .presetn      (presetn),
    .int_req      (int_req),
    .vector_fetch (int_vector_fetch),
    .pending      (int_pending),
    .vector       (int_vector),
    .src_ack      (int_src_ack)
  );

  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign prdata     = s_q.prdata;
  assign rst_pin_o  = s_q.rst_pin_out;
  assign rst_pin_oe = s_q.rst_pin_oe;
  assign bus_clock  = s_q.bus_clock;
  assign clocks_run = s_q.clocks_run;
  assign irq        = s_q.irq;

  // Helper: length of each reset pin hold.
  logic [12:0] hold_cnt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_cnt_q <= 13'h0;
    else if (restart)
      hold_cnt_q <= 13'h0;
    else if (s_q.rst_pin_oe)
      hold_cnt_q <= hold_cnt_q + 13'h1;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_brk_wait_set: assert property (break_wait_set |=> s_q.break_status[1])
    else $error("break wait flag not set");
  a_brk_reserved: assert property (
    (s_q.break_status & ~sysint_pkg::BREAK_STATUS_MASK) == 8'h00 &&
    (s_q.break_flag_control & ~sysint_pkg::BFC_MASK) == 8'h00)
    else $error("reserved bit became set");
  a_cause_por: assert property (reset_src.power_on_pulse |=> s_q.reset_cause == 8'h80)
    else $error("power-on did not leave only its cause bit");
  a_cause_wdog: assert property (
    reset_src.watchdog && !reset_src.power_on_pulse |=> s_q.reset_cause[5])
    else $error("watchdog cause bit not set");
  a_cause_ro: assert property (
    wr_done && idx == sysint_pkg::IDX_RESET_CAUSE && cause_bits == 8'h00 &&
    !reset_src.power_on_pulse |=> $stable(s_q.reset_cause))
    else $error("write changed reset cause");
  a_bfc_write: assert property (
    wr_done && idx == sysint_pkg::IDX_BREAK_FLAG_CONTROL |=>
    s_q.break_flag_control == {$past(pwdata[7]), 7'h00})
    else $error("break flag control write wrong");
  a_bus_half: assert property (
    clocks_run && $past(clocks_run) |-> bus_clock != $past(bus_clock))
    else $error("bus clock not half rate");
  a_hold_len: assert property ($fell(rst_pin_oe) |-> hold_cnt_q == 13'h1000)
    else $error("reset pin hold not 4096 cycles");
  a_hold_quiet: assert property (reset_src.low_voltage |=> (!clocks_run && rst_pin_oe)[*8])
    else $error("clocks ran during hold");
  a_answer_pulse: assert property (access && !pready |=> pready ##1 !pready)
    else $error("answer not a single cycle");

  c_startup: cover property ($fell(rst_pin_oe) ##[1:20] bus_clock);
  c_bfc_write: cover property (wr_done && idx == sysint_pkg::IDX_BREAK_FLAG_CONTROL);
  c_brk_clear: cover property (s_q.break_status[1] ##1 !s_q.break_status[1]);
  c_irq: cover property ($rose(irq));

endmodule : system_integration_unit

`default_nettype wire

// >>> verification/apb_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module apb_cpu_model (
  // Clock
  input  wire logic        pclk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'hffffffff;
    pwdata  = 32'h00000000;
  end

  // Released address and data lines show the inverse of the last value so a stale value is never read as valid.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    // Start on an edge so the setup phase never launches a few nanoseconds late.
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~wd;
    @(posedge pclk);
  endtask : xfer
endmodule : apb_cpu_model

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel, penable, pwrite, pready, pslverr, err;
  logic [31:0]            paddr, pwdata, prdata, rd, req;
  sysint_pkg::reset_src_t reset_src = '0;
  logic                   pin_low = 1'b0;
  logic                   rst_pin_i, rst_pin_o, rst_pin_oe, bus_clock, clocks_run;
  logic                   brk = 1'b0;
  logic                   bws = 1'b0;
  logic                   fetch = 1'b0;
  logic                   int_pending, irq;
  logic [23:0]            int_req = '0;
  logic [23:0]            ack;
  logic [15:0]            vec;
  int                     fails = 0;
  int                     n_compared = 0;
  int                     cyc = 0;
  int                     n;

  // The reset pin has a pull-up; either party may pull it low.
  assign rst_pin_i = !(rst_pin_oe || pin_low);

  initial
  begin
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  apb_cpu_model apb_cpu_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

  system_integration_unit system_integration_unit_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .reset_src(reset_src),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .break_active(brk), .break_wait_set(bws), .bus_clock(bus_clock),
    .clocks_run(clocks_run), .int_req(int_req), .int_vector_fetch(fetch),
    .int_pending(int_pending), .int_vector(vec), .int_src_ack(ack), .irq(irq));

  function automatic logic [31:0] ad(input logic [15:0] idx);
    return {14'h0, idx, 2'b00};
  endfunction : ad

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb_cpu_model_i.xfer(1'b1, ad(idx), d, rd, err);
  endtask : wr

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input string m);
    apb_cpu_model_i.xfer(1'b0, ad(idx), 32'h0, rd, err);
    chk(rd, exp, m);
  endtask : rdc

  task automatic pulse_src(input logic [4:0] s);
    @(posedge pclk);
    reset_src <= s;
    @(posedge pclk);
    reset_src <= '0;
  endtask : pulse_src

  task automatic pulse_bws;
    @(posedge pclk);
    bws <= 1'b1;
    @(posedge pclk);
    bws <= 1'b0;
  endtask : pulse_bws

  task automatic wait_startup(output int k);
    k = 0;
    do
    begin
      @(posedge pclk);
      #1;
      k++;
      if (clocks_run !== 1'b1)
        chk({31'h0, rst_pin_oe}, 32'h1, "pin held low");
    end
    while (clocks_run !== 1'b1 && k < 5000);
  endtask : wait_startup

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    rd = $urandom(78637);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_startup(n);
    chk(n, 32'd4096, "startup length");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      #1;
      chk({31'h0, bus_clock}, {31'h0, ~i[0]}, "bus clock");
    end
    $display("startup done");
    rdc(sysint_pkg::IDX_BREAK_STATUS, 32'h0, "bs reset");
    rdc(sysint_pkg::IDX_RESET_CAUSE, 32'h80, "rc reset");
    rdc(sysint_pkg::IDX_BREAK_FLAG_CONTROL, 32'h0, "bfc reset");
    wr(sysint_pkg::IDX_BREAK_STATUS, 32'hffffffff);
    rdc(sysint_pkg::IDX_BREAK_STATUS, 32'h0, "bs ones");
    wr(sysint_pkg::IDX_RESET_CAUSE, 32'h0);
    rdc(sysint_pkg::IDX_RESET_CAUSE, 32'h80, "rc ro");
    wr(sysint_pkg::IDX_BREAK_FLAG_CONTROL, 32'hffffffff);
    rdc(sysint_pkg::IDX_BREAK_FLAG_CONTROL, 32'h80, "bfc bits");
    wr(sysint_pkg::IDX_BREAK_FLAG_CONTROL, 32'h0);
    rdc(16'hfe02, 32'h0, "hole data");
    chk({31'h0, err}, 32'h1, "hole error");
    $display("registers done");
    pulse_bws();
    rdc(sysint_pkg::IDX_BREAK_STATUS, 32'h2, "bw set");
    brk <= 1'b1;
    wr(sysint_pkg::IDX_BREAK_STATUS, 32'h0);
    rdc(sysint_pkg::IDX_BREAK_STATUS, 32'h2, "bw kept");
    wr(sysint_pkg::IDX_BREAK_FLAG_CONTROL, 32'h80);
    wr(sysint_pkg::IDX_BREAK_STATUS, 32'h0);
    rdc(sysint_pkg::IDX_BREAK_STATUS, 32'h0, "bw clr");
    brk <= 1'b0;
    rdc(sysint_pkg::IDX_IRQ_STATUS, 32'h6, "irq status");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(sysint_pkg::IDX_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1, "irq up");
    wr(sysint_pkg::IDX_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h0, "irq clr");
    rdc(sysint_pkg::IDX_IRQ_STATUS, 32'h4, "w1c");
    $display("break and irq done");
    req = 32'h80;
    for (int i = 0; i < 3; i++)
    begin
      pulse_src(5'h08 >> i);
      req = req | (32'h20 >> i);
      rdc(sysint_pkg::IDX_RESET_CAUSE, req, "cause");
    end
    @(posedge pclk);
    pin_low <= 1'b1;
    repeat (3) @(posedge pclk);
    pin_low <= 1'b0;
    rdc(sysint_pkg::IDX_RESET_CAUSE, 32'hf8, "pin cause");
    pulse_src(5'h01);
    #1;
    chk({31'h0, rst_pin_oe}, 32'h1, "lv hold");
    chk({31'h0, rst_pin_o}, 32'h0, "pin drives low");
    rdc(sysint_pkg::IDX_RESET_CAUSE, 32'hfa, "lv cause");
    pulse_src(5'h10);
    rdc(sysint_pkg::IDX_RESET_CAUSE, 32'h80, "por cause");
    wait_startup(n);
    chk({31'h0, clocks_run}, 32'h1, "restart");
    $display("reset causes done");
    for (int i = 0; i < 40; i++)
    begin
      req = (i == 0) ? 32'h800000 : (i == 1) ? 32'h0 : {8'h0, 24'($urandom)};
      @(posedge pclk);
      int_req <= req[23:0];
      fetch <= 1'b1;
      @(posedge pclk);
      fetch <= 1'b0;
      #1;
      chk({8'h0, ack}, req & (~req + 32'h1), "ack");
      chk({31'h0, int_pending}, {31'h0, |req}, "pending");
      n = 0;
      while (req != 0 && !req[n])
        n++;
      if (req != 0)
        chk({16'h0, vec}, {16'h0, 16'hfffc - 16'(2 * n)}, "vector");
    end
    $display("arbiter done");
    finish_test();
  end
endmodule : tb

`default_nettype wire
